// file: bench/serial_flash_opcode_decoder_tb_top.sv
// Self-checking bench for the serial flash host controller against a device model.
`timescale 1ns/100ps
`default_nettype none
module serial_flash_opcode_decoder_tb_top;
   import sflash_pkg::*;
   logic mclk_in;
   logic reset_in;
   logic req_valid_in;
   logic wr_valid_in;
   logic req_ready_out;
   logic wr_take_out;
   logic rd_valid_out;
   logic done_out;
   logic err_out;
   logic got_done;
   logic got_err;
   req_s req_in;
   logic [7:0] wr_data_in;
   logic [7:0] rd_data_out;
   logic [7:0] last_rd;
   logic [3:0] io_in;
   logic [3:0] dev_o;
   pins_s pins_out;
   int errors = 0;
   int checks = 0;
   int nrd;
   int nwr;
   int cycles;

   assign io_in = (pins_out.io_oe & pins_out.io_o) | (~pins_out.io_oe & dev_o);

   sflash_host DUT (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .req_in(req_in),
      .req_valid_in(req_valid_in),
      .req_ready_out(req_ready_out),
      .wr_data_in(wr_data_in),
      .wr_valid_in(wr_valid_in),
      .wr_take_out(wr_take_out),
      .rd_data_out(rd_data_out),
      .rd_valid_out(rd_valid_out),
      .done_out(done_out),
      .err_out(err_out),
      .io_in(io_in),
      .pins_out(pins_out)
   );

   sflash_device_model #(.OUT_DELAY_NS(30)) u_flash (
      .pins_in(pins_out),
      .dev_o_out(dev_o)
   );

   initial begin
      mclk_in = 1'h0;
      forever #5 mclk_in = ~mclk_in;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // A stalled run withholds write data for 200 cycles to freeze the serial clock.
   task automatic run(input logic [7:0] op, input logic [23:0] a, input logic [15:0] n,
         input logic [7:0] d, input bit stall);
      nrd = 0;
      nwr = 0;
      got_done = 1'h0;
      got_err = 1'h0;
      req_in = '{opcode: op, addr: a, len: n};
      wr_data_in = d;
      wr_valid_in = !stall;
      req_valid_in = 1'h1;
      @(posedge mclk_in);
      #1 req_valid_in = 1'h0;
      for (cycles = 1; cycles < 8000 && !got_done && !got_err; cycles++) begin
         // The first pass looks at the cycle right after the take, where a refusal shows.
         if (cycles > 1) begin
            @(posedge mclk_in);
            #1;
         end
         if (cycles == 200) begin
            wr_valid_in = 1'h1;
         end
         if (rd_valid_out === 1'h1) begin
            nrd++;
            last_rd = rd_data_out;
         end
         if (wr_take_out === 1'h1) begin
            nwr++;
            wr_data_in = wr_data_in + 8'h11;
         end
         got_done = done_out === 1'h1;
         got_err = err_out === 1'h1;
      end
      chk(got_done | got_err, 1'h1, "completion");
      @(posedge mclk_in);
      #1;
      chk(req_ready_out, 1'h1, "ready after completion");
   endtask

   // Each entry: opcode, clock edges in the frame, bytes read, bytes written.
   task automatic sc_table;
      logic [23:0] t [0:42];
      t = '{24'h032810, 24'h0B3010, 24'h3B2C10, 24'hBB1C10, 24'h6B2A10, 24'hEB1210,
         24'hE71210, 24'h812000, 24'h202000, 24'h522000, 24'hD82000, 24'h022801,
         24'h322201, 24'h060800, 24'h040800, 24'h500800, 24'h362000, 24'h392000,
         24'h3D2000, 24'h7E0800, 24'h980800, 24'h442000, 24'h422801, 24'h483010,
         24'h051010, 24'h351010, 24'h151010, 24'h011001, 24'h311001, 24'h111001,
         24'hC81010, 24'h561001, 24'h9B3010, 24'h9E0800, 24'h9C2801, 24'h9A2000,
         24'h9D2000, 24'hB90800, 24'hAB2810, 24'hFF0800, 24'h922C10, 24'h942A10,
         24'h990800};
      foreach (t[i]) begin
         run(t[i][23:16], 24'h00ABCD, 16'h0001, 8'h3C, 1'h0);
         chk(u_flash.nedge_q, t[i][15:8], "edges");
         chk(nrd, t[i][7:4], "reads");
         chk(nwr, t[i][3:0], "writes");
      end
   endtask

   task automatic sc_refuse;
      logic [7:0] bad [0:11];
      int frames;
      bad = '{8'h9F, 8'h90, 8'h38, 8'h60, 8'hC7, 8'h75, 8'h7A, 8'h77, 8'h5A, 8'h4B, 8'h0C,
         8'hC0};
      frames = u_flash.nframe_q;
      foreach (bad[i]) begin
         run(bad[i], 24'h000000, 16'h0001, 8'h00, 1'h0);
         chk(got_err, 1'h1, "refusal");
      end
      chk(u_flash.nframe_q, frames, "frames");
   endtask

   task automatic sc_frames;
      run(8'h20, 24'h123456, 16'h0001, 8'h00, 1'h0);
      chk(u_flash.sh_q, 32'h20123456, "erase frame");
      run(8'h02, 24'h000100, 16'h0003, 8'hA1, 1'h0);
      chk(u_flash.sh_q[23:0], 24'hA1B2C3, "program data");
      chk(nwr, 32'h3, "program bytes");
      run(8'h01, 24'h000000, 16'h0001, 8'h96, 1'h1);
      chk(u_flash.sh_q[15:0], 16'h0196, "stalled write");
      run(8'hB9, 24'h000000, 16'h0001, 8'h00, 1'h0);
      run(8'hAB, 24'h000000, 16'h0001, 8'h00, 1'h0);
      chk(last_rd, 8'h17, "wake ident");
   endtask

   task automatic sc_lanes;
      logic [7:0] ops [0:5];
      ops = '{8'h03, 8'h3B, 8'hBB, 8'h6B, 8'hEB, 8'hE7};
      foreach (ops[i]) begin
         run(ops[i], 24'h000010, 16'h0002, 8'h00, 1'h0);
         chk(nrd, 32'h2, "read bytes");
         chk(last_rd, 8'h5B, "read data");
      end
   endtask

   task automatic sc_latch;
      run(8'h06, 24'h000000, 16'h0001, 8'h00, 1'h0);
      run(8'h05, 24'h000000, 16'h0001, 8'h00, 1'h0);
      chk(last_rd, 8'h02, "latch set");
      run(8'h04, 24'h000000, 16'h0001, 8'h00, 1'h0);
      run(8'h05, 24'h000000, 16'h0001, 8'h00, 1'h0);
      chk(last_rd, 8'h00, "latch clear");
      run(8'h50, 24'h000000, 16'h0001, 8'h00, 1'h0);
      run(8'h35, 24'h000000, 16'h0001, 8'h00, 1'h0);
      chk(last_rd, 8'h01, "volatile enable");
   endtask

   task automatic sc_reset;
      run(8'h06, 24'h000000, 16'h0001, 8'h00, 1'h0);
      run(8'h66, 24'h000000, 16'h0001, 8'h00, 1'h0);
      run(8'h99, 24'h000000, 16'h0001, 8'h00, 1'h0);
      chk(cycles > 3000 && cycles < 3200, 1'h1, "reset wait");
      run(8'h05, 24'h000000, 16'h0001, 8'h00, 1'h0);
      chk(last_rd, 8'h00, "state after reset");
   endtask

   initial begin
      #1000000;
      errors++;
      $display("unexpected at %0t: run did not finish", $time);
      tally_and_finish();
   end

   initial begin
      reset_in = 1'h1;
      req_valid_in = 1'h0;
      req_in = '0;
      wr_valid_in = 1'h0;
      wr_data_in = 8'h00;
      repeat (4) @(posedge mclk_in);
      #1 reset_in = 1'h0;
      @(posedge mclk_in);
      #1;
      sc_table();
      sc_refuse();
      sc_frames();
      sc_lanes();
      sc_latch();
      sc_reset();
      tally_and_finish();
   end
endmodule
`default_nettype wire

// file: bench/sflash_device_model.sv
// Behavioural serial flash answering the host controller over its pins.
`timescale 1ns/100ps
`default_nettype none
module sflash_device_model
   import sflash_pkg::*;
#(
   parameter int OUT_DELAY_NS = 30,
   parameter logic [7:0] ELEC_ID = 8'h17 // Arbitrary identification value.
)
(
   input wire pins_s pins_in,
   output logic [3:0] dev_o_out
);
   logic [7:0] op_q;
   logic [7:0] cur_q;
   logic [31:0] sh_q;
   int nedge_q = 0;
   int nframe_q = 0;
   int nbyte_q = 0;
   int bits_q = 0;
   logic wel_q = 1'h0;
   logic vsr_q = 1'h0;
   logic lock_all_q = 1'h0;
   logic sleep_q = 1'h0;
   logic arm_q = 1'h0;

   function automatic int hdr_edges(input logic [7:0] op);
      case (op)
         8'h05, 8'h35, 8'h15, 8'hC8: return 8;
         8'h03, 8'hAB: return 32;
         8'hBB: return 24;
         8'hEB, 8'hE7: return 16;
         default: return 40;
      endcase
   endfunction

   function automatic int out_lanes(input logic [7:0] op);
      case (op)
         8'h3B, 8'hBB, 8'h92: return 2;
         8'h6B, 8'hEB, 8'hE7, 8'h94: return 4;
         default: return 1;
      endcase
   endfunction

   function automatic bit is_read(input logic [7:0] op);
      case (op)
         8'h03, 8'h0B, 8'h3B, 8'hBB, 8'h6B, 8'hEB, 8'hE7, 8'h48: return 1'h1;
         8'h05, 8'h35, 8'h15, 8'hC8, 8'h9B, 8'hAB, 8'h92, 8'h94: return 1'h1;
         default: return 1'h0;
      endcase
   endfunction

   function automatic logic [7:0] byte_of(input logic [7:0] op, input int k);
      case (op)
         8'h05: return {6'h00, wel_q, 1'h0};
         8'h35: return {7'h00, vsr_q};
         8'hAB: return ELEC_ID;
         default: return 8'h5A + k[7:0];
      endcase
   endfunction

   initial begin
      dev_o_out = 4'h5;
   end

   always @(negedge pins_in.cs_n) begin
      nedge_q = 0;
      nbyte_q = 0;
      bits_q = 0;
      nframe_q++;
   end

   always @(posedge pins_in.sclk) begin
      if (!pins_in.cs_n) begin
         sh_q = {sh_q[30:0], pins_in.io_o[0]};
         nedge_q++;
         if (nedge_q == 8) begin
            op_q = sh_q[7:0];
         end
      end
   end

   // Released lines toggle so a host that samples them cannot read a stale level.
   always @(negedge pins_in.sclk) begin
      if (!pins_in.cs_n && is_read(op_q) && nedge_q >= hdr_edges(op_q) &&
            (!sleep_q || op_q == 8'hAB)) begin
         if (bits_q == 0) begin
            cur_q = byte_of(op_q, nbyte_q);
            nbyte_q++;
            bits_q = 8;
         end
         case (out_lanes(op_q))
            1: dev_o_out <= #(OUT_DELAY_NS) {~dev_o_out[3:2], cur_q[7], ~dev_o_out[0]};
            2: dev_o_out <= #(OUT_DELAY_NS) {~dev_o_out[3:2], cur_q[7:6]};
            default: dev_o_out <= #(OUT_DELAY_NS) cur_q[7:4];
         endcase
         cur_q = cur_q << out_lanes(op_q);
         bits_q = bits_q - out_lanes(op_q);
      end else begin
         dev_o_out <= ~dev_o_out;
      end
   end

   always @(posedge pins_in.cs_n) begin
      if (nedge_q == 8) begin
         case (op_q)
            8'h06: wel_q = 1'h1;
            8'h04: wel_q = 1'h0;
            8'h50: vsr_q = 1'h1;
            8'h7E: lock_all_q = 1'h1;
            8'h98: lock_all_q = 1'h0;
            8'hB9: sleep_q = 1'h1;
            8'h99: if (arm_q) begin
               wel_q = 1'h0;
               vsr_q = 1'h0;
               lock_all_q = 1'h0;
            end
            default: ;
         endcase
      end
      if (op_q == 8'h9D && nedge_q == 32) begin
         wel_q = 1'h0;
      end
      if (op_q == 8'hAB) begin
         sleep_q = 1'h0;
      end
      arm_q = nedge_q == 8 && op_q == 8'h66;
      dev_o_out <= ~dev_o_out;
   end
endmodule
`default_nettype wire

// file: bench/sflash_host_properties.sv
// Port-level assertions for the serial flash host controller.
`timescale 1ns/100ps
`default_nettype none
`include "sflash_defs.svh"
module sflash_host_properties
   import sflash_pkg::*;
(
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire req_s req_in,
   input wire logic req_valid_in,
   input wire logic req_ready_out,
   input wire logic [7:0] wr_data_in,
   input wire logic wr_valid_in,
   input wire logic wr_take_out,
   input wire logic [7:0] rd_data_out,
   input wire logic rd_valid_out,
   input wire logic done_out,
   input wire logic err_out,
   input wire logic [3:0] io_in,
   input wire pins_s pins_out
);
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (reset_in);

   property p_take;
      req_valid_in && req_ready_out |=> err_out == pins_out.cs_n;
   endproperty
   a_take: assert property (p_take) else $error("refusal and chip select disagree");

   property p_refuse_quiet;
      err_out |-> pins_out.cs_n && req_ready_out && pins_out.io_oe == `IO_IDLE_OE;
   endproperty
   a_refuse_quiet: assert property (p_refuse_quiet) else $error("refused opcode moved pins");

   property p_first_bit;
      req_valid_in && req_ready_out ##1 !pins_out.cs_n |->
         pins_out.io_oe[0] && pins_out.io_o[0] == $past(req_in.opcode[7]);
   endproperty
   a_first_bit: assert property (p_first_bit) else $error("opcode not sent top bit first");

   property p_idle;
      pins_out.cs_n |-> !pins_out.sclk && pins_out.io_o == `IO_IDLE_OUT;
   endproperty
   a_idle: assert property (p_idle) else $error("clock or data active while deselected");

   property p_high_four;
      $rose(pins_out.sclk) |-> pins_out.sclk [*4] ##1 !pins_out.sclk;
   endproperty
   a_high_four: assert property (p_high_four) else $error("serial clock high phase wrong");

   property p_hold_data;
      $rose(pins_out.sclk) |=> $stable(pins_out.io_o) [*3];
   endproperty
   a_hold_data: assert property (p_hold_data) else $error("data moved while clock high");

   property p_cs_edge;
      $rose(pins_out.cs_n) |-> !$past(pins_out.sclk) && !$past(pins_out.sclk, 4);
   endproperty
   a_cs_edge: assert property (p_cs_edge) else $error("deselect inside a clock period");

   property p_done_late;
      done_out |-> pins_out.cs_n && $past(pins_out.cs_n, 3);
   endproperty
   a_done_late: assert property (p_done_late) else $error("done before deselect");

   property p_take_pulse;
      wr_take_out |-> $past(wr_valid_in) && !pins_out.cs_n;
   endproperty
   a_take_pulse: assert property (p_take_pulse) else $error("write byte taken unoffered");

   property p_rd_in_frame;
      rd_valid_out |-> !pins_out.cs_n ##1 !rd_valid_out;
   endproperty
   a_rd_in_frame: assert property (p_rd_in_frame) else $error("read strobe outside a frame");
endmodule

bind sflash_host sflash_host_properties u_props (
   .mclk_in(mclk_in),
   .reset_in(reset_in),
   .req_in(req_in),
   .req_valid_in(req_valid_in),
   .req_ready_out(req_ready_out),
   .wr_data_in(wr_data_in),
   .wr_valid_in(wr_valid_in),
   .wr_take_out(wr_take_out),
   .rd_data_out(rd_data_out),
   .rd_valid_out(rd_valid_out),
   .done_out(done_out),
   .err_out(err_out),
   .io_in(io_in),
   .pins_out(pins_out)
);
`default_nettype wire

// file: design/sflash_defs.svh
// Opcodes, reset values and timing counts for the serial flash host controller.
`ifndef SFLASH_DEFS_SVH
`define SFLASH_DEFS_SVH

`define OPC_LOW_POWER_READ 8'h03
`define OPC_FAST_ARRAY_READ 8'h0B
`define OPC_DUAL_OUTPUT_READ 8'h3B
`define OPC_TWO_LINE_IO_READ 8'hBB
`define OPC_QUAD_OUTPUT_READ 8'h6B
`define OPC_FOUR_LINE_IO_READ 8'hEB
`define OPC_WORD_FOUR_LINE_READ 8'hE7
`define OPC_PAGE_ERASE 8'h81
`define OPC_SECTOR_ERASE 8'h20
`define OPC_HALF_BLOCK_ERASE 8'h52
`define OPC_FULL_BLOCK_ERASE 8'hD8
`define OPC_PAGE_PROGRAM 8'h02
`define OPC_QUAD_PAGE_PROGRAM 8'h32
`define OPC_SET_WRITE_LATCH 8'h06
`define OPC_CLEAR_WRITE_LATCH 8'h04
`define OPC_VOLATILE_STATUS_WRITE_ENABLE 8'h50
`define OPC_SINGLE_BLOCK_LOCK 8'h36
`define OPC_SINGLE_BLOCK_UNLOCK 8'h39
`define OPC_BLOCK_LOCK_STATE_READ 8'h3D
`define OPC_ALL_BLOCKS_LOCK 8'h7E
`define OPC_ALL_BLOCKS_UNLOCK 8'h98
`define OPC_SECURE_AREA_ERASE 8'h44
`define OPC_SECURE_AREA_PROGRAM 8'h42
`define OPC_SECURE_AREA_READ 8'h48
`define OPC_STATUS_ONE_READ 8'h05
`define OPC_STATUS_TWO_READ 8'h35
`define OPC_CONFIG_REG_READ 8'h15
`define OPC_STATUS_ONE_WRITE 8'h01
`define OPC_STATUS_TWO_WRITE 8'h31
`define OPC_CONFIG_REG_WRITE 8'h11
`define OPC_UPPER_ADDRESS_REG_READ 8'hC8
`define OPC_UPPER_ADDRESS_REG_WRITE 8'h56
`define OPC_BUFFER_READ 8'h9B
`define OPC_BUFFER_CLEAR 8'h9E
`define OPC_BUFFER_WRITE 8'h9C
`define OPC_BUFFER_LOAD 8'h9A
`define OPC_BUFFER_COMMIT_PROGRAM 8'h9D
`define OPC_DEEP_SLEEP_ENTER 8'hB9
`define OPC_DEEP_SLEEP_EXIT_IDENT 8'hAB
`define OPC_ENHANCED_READ_END 8'hFF
`define OPC_DUAL_IDENT_READ 8'h92
`define OPC_QUAD_IDENT_READ 8'h94
`define OPC_RESET_ARM 8'h66
`define OPC_RESET_FIRE 8'h99

`define IO_IDLE_OUT 4'hC
`define IO_IDLE_OE 4'hD
`define SCLK_DIV_LAST 2'h3
`define MCLK_PERIOD_NS 10
`define RESET_WAIT_NS 30000
`define RESET_WAIT_CYC ((`RESET_WAIT_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`endif

// file: design/sflash_host.sv
// Host controller that frames opcode, address, dummy and data bytes for a serial flash.
//
// Overview of operation
// - 03h/0Bh read, three address, 0Bh one dummy.
// - 3Bh: single-line address and dummy, two-line data.
// - BBh: address, dummy and data on two lines.
// - 6Bh: single-line address and dummy, four-line data.
// - EBh: address, dummy and data on four lines.
// - E7h: four-line word read, address plus dummy.
// - 81h/20h page and sector erase, address only.
// - 52h/D8h block erases, three address bytes only.
// - 02h/32h program: address then single/quad data.
// - 36h/39h/3Dh block lock commands take address.
// - 44h/42h/48h security erase, program, read framing.
// - 01h/31h/11h write exactly one data byte.
// - C8h/56h extended address read/write, one byte.
// - 9Bh buffer read with dummy; 9Eh bare.
// - 9Ch buffer write data; 9Ah load, address.
// - Chip select rises only on byte boundaries.
// - 66h then 99h; wait 30 us afterwards.
// - Device samples rising edge, shifts falling; mode 0.
`timescale 1ns/100ps
`default_nettype none
`include "sflash_defs.svh"

module sflash_host
   import sflash_pkg::*;
(
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire req_s req_in,
   input wire logic req_valid_in,
   output logic req_ready_out,
   input wire logic [7:0] wr_data_in,
   input wire logic wr_valid_in,
   output logic wr_take_out,
   output logic [7:0] rd_data_out,
   output logic rd_valid_out,
   output logic done_out,
   output logic err_out,
   input wire logic [3:0] io_in,
   output pins_s pins_out
);

   localparam state_s RESET_STATE = '{
      st: ST_IDLE, ph: PH_OPC,
      fr: '{ok: 1'b0, n_addr: 2'h0, n_dummy: 1'b0, dir: DIR_NONE,
            a_ln: LN1, d_ln: LN1, one_byte: 1'b0},
      op: 8'h00, adr: 24'h000000, adr_left: 2'h0, dmy_left: 1'b0, dcnt: 16'h0000,
      sh: 8'h00, bits: 4'h0, div: 2'h0, wait_cnt: 12'h000, armed: 1'b0,
      s1: 4'h0, s2: 4'h0,
      pin: '{sclk: 1'b0, cs_n: 1'b1, io_o: `IO_IDLE_OUT, io_oe: `IO_IDLE_OE},
      rd_data: 8'h00, rd_valid: 1'b0, wr_take: 1'b0, done: 1'b0, err: 1'b0, rdy: 1'b1};

   localparam logic [11:0] RESET_WAIT = 12'(`RESET_WAIT_CYC);

   state_s q;
   state_s d;
   frame_s f;
   lanes_e ln;
   logic [7:0] nsh;
   logic fin;

   function automatic frame_s decode_op(input logic [7:0] op);
      frame_s r;
      r = '{ok: 1'b1, n_addr: 2'h0, n_dummy: 1'b0, dir: DIR_NONE,
            a_ln: LN1, d_ln: LN1, one_byte: 1'b0};
      unique case (op)
         `OPC_LOW_POWER_READ: begin
            r.n_addr = 2'h3; r.dir = DIR_RD;
         end
         `OPC_FAST_ARRAY_READ, `OPC_SECURE_AREA_READ, `OPC_BUFFER_READ: begin
            r.n_addr = 2'h3; r.n_dummy = 1'b1; r.dir = DIR_RD;
         end
         `OPC_DUAL_OUTPUT_READ, `OPC_DUAL_IDENT_READ: begin
            r.n_addr = 2'h3; r.n_dummy = 1'b1; r.dir = DIR_RD; r.d_ln = LN2;
         end
         `OPC_TWO_LINE_IO_READ: begin
            r.n_addr = 2'h3; r.n_dummy = 1'b1; r.dir = DIR_RD;
            r.a_ln = LN2; r.d_ln = LN2;
         end
         `OPC_QUAD_OUTPUT_READ, `OPC_QUAD_IDENT_READ: begin
            r.n_addr = 2'h3; r.n_dummy = 1'b1; r.dir = DIR_RD; r.d_ln = LN4;
         end
         `OPC_FOUR_LINE_IO_READ, `OPC_WORD_FOUR_LINE_READ: begin
            r.n_addr = 2'h3; r.n_dummy = 1'b1; r.dir = DIR_RD;
            r.a_ln = LN4; r.d_ln = LN4;
         end
         `OPC_PAGE_ERASE, `OPC_SECTOR_ERASE, `OPC_HALF_BLOCK_ERASE, `OPC_FULL_BLOCK_ERASE,
         `OPC_SINGLE_BLOCK_LOCK, `OPC_SINGLE_BLOCK_UNLOCK, `OPC_BLOCK_LOCK_STATE_READ,
         `OPC_SECURE_AREA_ERASE, `OPC_BUFFER_LOAD, `OPC_BUFFER_COMMIT_PROGRAM: begin
            r.n_addr = 2'h3;
         end
         `OPC_PAGE_PROGRAM, `OPC_SECURE_AREA_PROGRAM, `OPC_BUFFER_WRITE: begin
            r.n_addr = 2'h3; r.dir = DIR_WR;
         end
         `OPC_QUAD_PAGE_PROGRAM: begin
            r.n_addr = 2'h3; r.dir = DIR_WR; r.d_ln = LN4;
         end
         `OPC_SET_WRITE_LATCH, `OPC_CLEAR_WRITE_LATCH, `OPC_VOLATILE_STATUS_WRITE_ENABLE,
         `OPC_ALL_BLOCKS_LOCK, `OPC_ALL_BLOCKS_UNLOCK, `OPC_BUFFER_CLEAR,
         `OPC_DEEP_SLEEP_ENTER, `OPC_ENHANCED_READ_END, `OPC_RESET_ARM,
         `OPC_RESET_FIRE: begin
            r.n_addr = 2'h0;
         end
         `OPC_STATUS_ONE_READ, `OPC_STATUS_TWO_READ, `OPC_CONFIG_REG_READ,
         `OPC_UPPER_ADDRESS_REG_READ: begin
            r.dir = DIR_RD; r.one_byte = 1'b1;
         end
         `OPC_STATUS_ONE_WRITE, `OPC_STATUS_TWO_WRITE, `OPC_CONFIG_REG_WRITE,
         `OPC_UPPER_ADDRESS_REG_WRITE: begin
            r.dir = DIR_WR; r.one_byte = 1'b1;
         end
         `OPC_DEEP_SLEEP_EXIT_IDENT: begin
            r.n_addr = 2'h3; r.dir = DIR_RD; r.one_byte = 1'b1;
         end
         default: r.ok = 1'b0;
      endcase
      return r;
   endfunction

   function automatic lanes_e lane_of(input frame_s fr, input phase_e p);
      unique case (p)
         PH_OPC: return LN1;
         PH_ADDR, PH_DUMMY: return fr.a_ln;
         PH_WDATA, PH_RDATA: return fr.d_ln;
      endcase
   endfunction

   function automatic logic [3:0] clks(input lanes_e l);
      unique case (l)
         LN1: return 4'h8;
         LN2: return 4'h4;
         LN4: return 4'h2;
      endcase
   endfunction

   // Outside quad transfers, lines 2 and 3 are held high so write protect and hold stay idle.
   function automatic logic [3:0] out_bits(input logic [7:0] b, input lanes_e l);
      unique case (l)
         LN1: return {2'h3, 1'b0, b[7]};
         LN2: return {2'h3, b[7:6]};
         LN4: return b[7:4];
      endcase
   endfunction

   function automatic logic [3:0] oe_for(input phase_e p, input lanes_e l);
      if (l == LN1) begin
         return 4'hD;
      end
      if (p == PH_RDATA) begin
         return (l == LN2) ? 4'hC : 4'h0;
      end
      return 4'hF;
   endfunction

   function automatic logic [7:0] shift_in(input logic [7:0] s, input lanes_e l,
                                           input logic [3:0] i);
      unique case (l)
         LN1: return {s[6:0], i[1]};
         LN2: return {s[5:0], i[1:0]};
         LN4: return {s[3:0], i[3:0]};
      endcase
   endfunction

   function automatic state_s load_byte(input state_s s, input phase_e p, input logic [7:0] b);
      state_s r;
      lanes_e l;
      r = s;
      l = lane_of(s.fr, p);
      r.ph = p;
      r.sh = b;
      r.bits = clks(l);
      r.pin.io_o = out_bits(b, l);
      r.pin.io_oe = oe_for(p, l);
      return r;
   endfunction

   always_comb begin
      d = q;
      f = decode_op(req_in.opcode);
      ln = LN1;
      nsh = 8'h00;
      fin = 1'b0;
      d.s1 = io_in;
      d.s2 = q.s1;
      d.rd_valid = 1'b0;
      d.wr_take = 1'b0;
      d.done = 1'b0;
      d.err = 1'b0;
      unique case (q.st)
         ST_IDLE: begin
            if (req_valid_in && !f.ok) begin
               d.err = 1'b1;
            end else if (req_valid_in) begin
               d.fr = f;
               d.op = req_in.opcode;
               d.adr = req_in.addr;
               d.adr_left = f.n_addr;
               d.dmy_left = f.n_dummy;
               if (f.dir == DIR_NONE) begin
                  d.dcnt = 16'h0000;
               end else if (f.one_byte || req_in.len == 16'h0000) begin
                  d.dcnt = 16'h0001;
               end else begin
                  d.dcnt = req_in.len;
               end
               d.pin.cs_n = 1'b0;
               d.div = 2'h0;
               d.st = ST_RUN;
               d = load_byte(d, PH_OPC, req_in.opcode);
            end
         end
         ST_RUN: begin
            d.div = 2'(q.div + 2'h1);
            if (q.div == `SCLK_DIV_LAST && !q.pin.sclk) begin
               d.pin.sclk = 1'b1;
            end else if (q.div == `SCLK_DIV_LAST) begin
               // The synchronised lines lag the pins by two cycles, so this sample sits
               // inside the high phase, well after the device shifted on the last fall.
               d.pin.sclk = 1'b0;
               ln = lane_of(q.fr, q.ph);
               nsh = shift_in(q.sh, ln, q.s2 & {4{q.ph == PH_RDATA}});
               d.sh = nsh;
               d.bits = 4'(q.bits - 4'h1);
               d.pin.io_o = out_bits(nsh, ln);
               if (q.bits == 4'h1) begin
                  fin = 1'b1;
                  d.rd_data = (q.ph == PH_RDATA) ? nsh : q.rd_data;
                  d.rd_valid = (q.ph == PH_RDATA);
               end
            end
         end
         ST_STALL: begin
            // The clock simply stops low while the source has no byte ready.
            if (wr_valid_in) begin
               d = load_byte(d, PH_WDATA, wr_data_in);
               d.wr_take = 1'b1;
               d.dcnt = 16'(q.dcnt - 16'h0001);
               d.div = 2'h0;
               d.st = ST_RUN;
            end
         end
         ST_TAIL: begin
            d.div = 2'(q.div + 2'h1);
            if (q.div == `SCLK_DIV_LAST) begin
               d.pin.cs_n = 1'b1;
               d.pin.io_o = `IO_IDLE_OUT;
               d.pin.io_oe = `IO_IDLE_OE;
               d.st = ST_GAP;
            end
         end
         ST_GAP: begin
            d.div = 2'(q.div + 2'h1);
            if (q.div == `SCLK_DIV_LAST) begin
               d.armed = (q.op == `OPC_RESET_ARM);
               if (q.op == `OPC_RESET_FIRE && q.armed) begin
                  d.wait_cnt = RESET_WAIT;
                  d.st = ST_RSTWAIT;
               end else begin
                  d.done = 1'b1;
                  d.st = ST_IDLE;
               end
            end
         end
         ST_RSTWAIT: begin
            d.wait_cnt = 12'(q.wait_cnt - 12'h001);
            if (q.wait_cnt == 12'h001) begin
               d.done = 1'b1;
               d.st = ST_IDLE;
            end
         end
      endcase
      if (fin) begin
         if (q.adr_left != 2'h0) begin
            d = load_byte(d, PH_ADDR, q.adr[23:16]);
            d.adr = {q.adr[15:0], 8'h00};
            d.adr_left = 2'(q.adr_left - 2'h1);
         end else if (q.dmy_left) begin
            d = load_byte(d, PH_DUMMY, 8'h00);
            d.dmy_left = 1'b0;
         end else if (q.dcnt != 16'h0000 && q.fr.dir == DIR_RD) begin
            d = load_byte(d, PH_RDATA, 8'h00);
            d.dcnt = 16'(q.dcnt - 16'h0001);
         end else if (q.dcnt != 16'h0000 && wr_valid_in) begin
            d = load_byte(d, PH_WDATA, wr_data_in);
            d.wr_take = 1'b1;
            d.dcnt = 16'(q.dcnt - 16'h0001);
         end else if (q.dcnt != 16'h0000) begin
            d.st = ST_STALL;
         end else begin
            d.div = 2'h0;
            d.st = ST_TAIL;
         end
      end
      d.rdy = (d.st == ST_IDLE);
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         q <= RESET_STATE;
      end else begin
         q <= d;
      end
   end

   assign req_ready_out = q.rdy;
   assign wr_take_out = q.wr_take;
   assign rd_data_out = q.rd_data;
   assign rd_valid_out = q.rd_valid;
   assign done_out = q.done;
   assign err_out = q.err;
   assign pins_out = q.pin;

endmodule
`default_nettype wire

// file: design/sflash_pkg.sv
// Types shared by the serial flash host controller and its bench.
package sflash_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_STALL, ST_TAIL, ST_GAP, ST_RSTWAIT} st_e;
   typedef enum logic [2:0] {PH_OPC, PH_ADDR, PH_DUMMY, PH_WDATA, PH_RDATA} phase_e;
   typedef enum logic [1:0] {LN1, LN2, LN4} lanes_e;
   typedef enum logic [1:0] {DIR_NONE, DIR_RD, DIR_WR} dir_e;

   typedef struct packed {
      logic ok;
      logic [1:0] n_addr;
      logic n_dummy;
      dir_e dir;
      lanes_e a_ln;
      lanes_e d_ln;
      logic one_byte;
   } frame_s;

   typedef struct packed {
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [15:0] len;
   } req_s;

   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic [3:0] io_o;
      logic [3:0] io_oe;
   } pins_s;

   typedef struct packed {
      st_e st;
      phase_e ph;
      frame_s fr;
      logic [7:0] op;
      logic [23:0] adr;
      logic [1:0] adr_left;
      logic dmy_left;
      logic [15:0] dcnt;
      logic [7:0] sh;
      logic [3:0] bits;
      logic [1:0] div;
      logic [11:0] wait_cnt;
      logic armed;
      logic [3:0] s1;
      logic [3:0] s2;
      pins_s pin;
      logic [7:0] rd_data;
      logic rd_valid;
      logic wr_take;
      logic done;
      logic err;
      logic rdy;
   } state_s;
endpackage
